// ---- wsa_alu.v ----
// word add-immediate and byte subtract datapath with its register file and flags
// assumes the decoder and the register port run on clk and obey the strobe timing
//
// Summary of operation
// RQ1 - word add: pair plus constant, sets Z C N V S, two cycles
// RQ2 - subtract constant: destination minus byte, stored, sets Z C N V H, one cycle
// RQ3 - register borrow subtract: minus source and carry, sets Z C N V H, one cycle
// RQ4 - constant borrow subtract: minus byte and carry, sets Z C N V H, one cycle
// RQ5 - register subtract: destination minus source, stored, sets Z C N V H, one cycle
`timescale 1ns/10ps
`include "wsa_defs.vh"

module wsa_alu #(
    parameter NUM_REGS = 32
) (
    input  wire                   clk,
    input  wire                   rst,
    // operation request from the decoder
    input  wire                   opValid,
    input  wire [`WSA_OP_W-1:0]   opCode,
    input  wire [4:0]             dstSel,
    input  wire [4:0]             srcSel,
    input  wire [7:0]             immVal,
    output reg                    busy_ff,
    output reg                    done_ff,
    output reg                    reject_ff,
    // register port
    input  wire [`WSA_ADDR_W-1:0] regAddr,
    input  wire [7:0]             regWrData,
    input  wire                   regWrEn,
    input  wire                   regRdEn,
    output reg  [7:0]             regRdData_ff
);

    // ------------------------------------------------------------------
    // states
    // ------------------------------------------------------------------
    // one-hot: idle, or the second step of the word add
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_HIGH = 2'b10;

    reg  [1:0] state_ff;
    reg  [1:0] nxt_state;

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    reg  [7:0] gpr_ff [0:NUM_REGS-1];
    reg  [7:0] status_ff;
    reg  [7:0] nxt_status;
    reg  [4:0] pairLo_ff;
    reg  [4:0] nxt_pairLo;
    reg  [7:0] lowByte_ff;
    reg  [7:0] nxt_lowByte;
    reg        lowCarry_ff;
    reg        nxt_lowCarry;
    reg        nxt_busy;
    reg        nxt_done;
    reg        nxt_reject;
    reg  [7:0] nxt_rdData;

    // ------------------------------------------------------------------
    // request decode
    // ------------------------------------------------------------------
    wire       reqTake;
    wire       isWord;
    wire       isSubReg;
    wire       isSubImm;
    wire       isSubRegBorrow;
    wire       isSubImmBorrow;
    wire       isByteOp;
    wire       useImm;
    wire [4:0] byteDst;
    wire [4:0] pairLoSel;
    wire [7:0] subA;
    wire [7:0] subB;
    wire       subBorrowIn;

    assign reqTake        = opValid & state_ff[0];
    assign isWord         = (opCode == `WSA_OP_ADD_IMMEDIATE_WORD);
    assign isSubReg       = (opCode == `WSA_OP_SUBTRACT_REGISTERS);
    assign isSubImm       = (opCode == `WSA_OP_SUBTRACT_CONSTANT);
    assign isSubRegBorrow = (opCode == `WSA_OP_SUBTRACT_REGISTERS_BORROW);
    assign isSubImmBorrow = (opCode == `WSA_OP_SUBTRACT_CONSTANT_BORROW);
    assign isByteOp       = isSubReg | isSubImm | isSubRegBorrow | isSubImmBorrow;
    assign useImm         = isSubImm | isSubImmBorrow;

    // constant forms reach only the upper bank of sixteen registers
    assign byteDst     = useImm ? {`WSA_UPPER_BANK, dstSel[3:0]} : dstSel;
    // word form reaches the four even pairs at the top of the file
    assign pairLoSel   = {`WSA_PAIR_PREFIX, dstSel[1:0], 1'b0};
    assign subA        = gpr_ff[byteDst];
    assign subB        = useImm ? immVal : gpr_ff[srcSel];
    // borrow forms chain the current carry into the difference
    assign subBorrowIn = (isSubRegBorrow | isSubImmBorrow) & status_ff[`WSA_FLAG_C]; // [RQ3] [RQ4]

    // ------------------------------------------------------------------
    // byte subtractor
    // ------------------------------------------------------------------
    wire [7:0] subDiff;
    wire       subC;
    wire       subZ;
    wire       subN;
    wire       subV;
    wire       subH;

    wsa_sub8 u_sub8 (
        .minuend    (subA),
        .subtrahend (subB),
        .borrowIn   (subBorrowIn),
        .diff       (subDiff),
        .borrowOut  (subC),
        .zero       (subZ),
        .neg        (subN),
        .ovf        (subV),
        .halfBorrow (subH)
    );

    // ------------------------------------------------------------------
    // word adder, low byte first then high byte with the carry
    // ------------------------------------------------------------------
    wire [8:0]  lowSum;
    wire [8:0]  highSum;
    wire [7:0]  highOrig;
    wire [4:0]  pairHi;
    wire [15:0] wordRes;
    wire        wordZ;
    wire        wordN;
    wire        wordV;
    wire        wordC;

    // only the low six bits of the constant reach the word adder
    assign lowSum   = {1'b0, gpr_ff[pairLoSel]} +
                      {{(9-`WSA_WORD_IMM_W){1'b0}}, immVal[`WSA_WORD_IMM_W-1:0]}; // [RQ1]
    assign pairHi   = {pairLo_ff[4:1], 1'b1};
    assign highOrig = gpr_ff[pairHi];
    assign highSum  = {1'b0, highOrig} + {8'h00, lowCarry_ff}; // [RQ1]
    assign wordRes  = {highSum[7:0], lowByte_ff};
    assign wordZ    = (wordRes == 16'h0000);
    assign wordN    = wordRes[15];
    // V when a positive word turned negative, C when a negative word wrapped past zero
    assign wordV    = ~highOrig[7] & wordRes[15];
    assign wordC    = highOrig[7] & ~wordRes[15];

    // ------------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------------
    always @* begin
        nxt_state    = state_ff;
        nxt_pairLo   = pairLo_ff;
        nxt_lowByte  = lowByte_ff;
        nxt_lowCarry = lowCarry_ff;
        nxt_done     = 1'b0;
        nxt_reject   = 1'b0;
        // a request seen while busy is dropped, not queued
        case (state_ff)
            ST_IDLE: begin
                if (reqTake && isWord) begin
                    nxt_state    = ST_HIGH; // [RQ1]
                    nxt_pairLo   = pairLoSel;
                    nxt_lowByte  = lowSum[7:0];
                    nxt_lowCarry = lowSum[8];
                end else if (reqTake && isByteOp) begin
                    nxt_done     = 1'b1; // [RQ2] [RQ3] [RQ4] [RQ5]
                end else if (reqTake) begin
                    nxt_reject   = 1'b1;
                end
            end
            ST_HIGH: begin
                nxt_state = ST_IDLE;
                nxt_done  = 1'b1; // [RQ1]
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
        nxt_busy = nxt_state[1];
    end

    // ------------------------------------------------------------------
    // writeback selection
    // ------------------------------------------------------------------
    reg        opWrEn;
    reg  [4:0] opWrIdx;
    reg  [7:0] opWrData;
    reg        flagWrEn;
    reg  [7:0] opFlags;

    always @* begin
        opWrEn   = 1'b0;
        opWrIdx  = 5'h00;
        opWrData = 8'h00;
        flagWrEn = 1'b0;
        opFlags  = status_ff;
        if (state_ff[1]) begin
            opWrEn                = 1'b1;
            opWrIdx               = pairHi;
            opWrData              = highSum[7:0]; // [RQ1]
            flagWrEn              = 1'b1;
            opFlags[`WSA_FLAG_Z]  = wordZ;
            opFlags[`WSA_FLAG_C]  = wordC;
            opFlags[`WSA_FLAG_N]  = wordN;
            opFlags[`WSA_FLAG_V]  = wordV;
            opFlags[`WSA_FLAG_S]  = wordN ^ wordV; // [RQ1]
        end else if (reqTake && isWord) begin
            opWrEn                = 1'b1;
            opWrIdx               = pairLoSel;
            opWrData              = lowSum[7:0]; // [RQ1]
        end else if (reqTake && isByteOp) begin
            opWrEn                = 1'b1;
            opWrIdx               = byteDst;
            opWrData              = subDiff; // [RQ2] [RQ3] [RQ4] [RQ5]
            flagWrEn              = 1'b1;
            opFlags[`WSA_FLAG_Z]  = subZ;
            opFlags[`WSA_FLAG_C]  = subC;
            opFlags[`WSA_FLAG_N]  = subN;
            opFlags[`WSA_FLAG_V]  = subV;
            opFlags[`WSA_FLAG_H]  = subH; // [RQ2] [RQ3] [RQ4] [RQ5]
        end
    end

    // ------------------------------------------------------------------
    // register port decode
    // ------------------------------------------------------------------
    wire busGprWr;
    wire busStatusWr;

    assign busGprWr    = regWrEn & (regAddr <= `WSA_ADDR_GPR_LAST);
    assign busStatusWr = regWrEn & (regAddr == `WSA_ADDR_STATUS);

    always @* begin
        nxt_status = status_ff;
        // the datapath wins over a software write in the same cycle
        if (flagWrEn) begin
            nxt_status = opFlags;
        end else if (busStatusWr) begin
            nxt_status = regWrData;
        end
    end

    always @* begin
        nxt_rdData = 8'h00;
        if (!regRdEn) begin
            nxt_rdData = 8'h00;
        end else if (regAddr <= `WSA_ADDR_GPR_LAST) begin
            nxt_rdData = gpr_ff[regAddr[4:0]];
        end else if (regAddr == `WSA_ADDR_STATUS) begin
            nxt_rdData = status_ff;
        end else if (regAddr == `WSA_ADDR_ENGINE) begin
            nxt_rdData[`WSA_ENGINE_BUSY] = busy_ff;
        end
    end

    // ------------------------------------------------------------------
    // general purpose registers, one writer process per entry
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NUM_REGS; gi = gi + 1) begin : g_gpr
            localparam [4:0] GPR_IDX = gi;
            // datapath write beats a software write to the same entry
            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    gpr_ff[gi] <= `WSA_GPR_RST;
                end else if (opWrEn && (opWrIdx == GPR_IDX)) begin
                    gpr_ff[gi] <= opWrData;
                end else if (busGprWr && (regAddr[4:0] == GPR_IDX)) begin
                    gpr_ff[gi] <= regWrData;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // control and status flops
    // ------------------------------------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff     <= ST_IDLE;
            status_ff    <= `WSA_STATUS_RST;
            pairLo_ff    <= 5'h00;
            lowByte_ff   <= 8'h00;
            lowCarry_ff  <= 1'b0;
            busy_ff      <= 1'b0;
            done_ff      <= 1'b0;
            reject_ff    <= 1'b0;
            regRdData_ff <= 8'h00;
        end else begin
            state_ff     <= nxt_state;
            status_ff    <= nxt_status;
            pairLo_ff    <= nxt_pairLo;
            lowByte_ff   <= nxt_lowByte;
            lowCarry_ff  <= nxt_lowCarry;
            busy_ff      <= nxt_busy;
            done_ff      <= nxt_done;
            reject_ff    <= nxt_reject;
            regRdData_ff <= nxt_rdData;
        end
    end

endmodule // wsa_alu

// ---- wsa_alu_checker.sv ----
// port checker for the word add and byte subtract datapath slice
// assumes binding onto wsa_alu, one clock domain, reset active high
`timescale 1ns/10ps
`include "wsa_defs.vh"

module wsa_alu_checker #(
    parameter NUM_REGS = 32
) (
    input wire                   clk,
    input wire                   rst,
    input wire                   opValid,
    input wire [`WSA_OP_W-1:0]   opCode,
    input wire [4:0]             dstSel,
    input wire [4:0]             srcSel,
    input wire [7:0]             immVal,
    input wire                   busy_ff,
    input wire                   done_ff,
    input wire                   reject_ff,
    input wire [`WSA_ADDR_W-1:0] regAddr,
    input wire [7:0]             regWrData,
    input wire                   regWrEn,
    input wire                   regRdEn,
    input wire [7:0]             regRdData_ff
);
    wire taken = opValid && !busy_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_word_two_cycles:
    assert property (taken && opCode == `WSA_OP_ADD_IMMEDIATE_WORD
        |=> busy_ff && !done_ff ##1 !busy_ff && done_ff) else $error("word op timing wrong");
    a_busy_from_word:
    assert property (busy_ff |-> $past(taken) && $past(opCode) == `WSA_OP_ADD_IMMEDIATE_WORD)
        else $error("busy without word op");
    a_busy_one_cycle:
    assert property (busy_ff |=> !busy_ff) else $error("busy longer than one cycle");
    a_const_sub_timing:
    assert property (taken && opCode == `WSA_OP_SUBTRACT_CONSTANT
        |=> done_ff && !busy_ff && !reject_ff) else $error("subtract constant timing wrong");
    a_reg_borrow_timing:
    assert property (taken && opCode == `WSA_OP_SUBTRACT_REGISTERS_BORROW
        |=> done_ff && !busy_ff && !reject_ff) else $error("register borrow timing wrong");
    a_const_borrow_timing:
    assert property (taken && opCode == `WSA_OP_SUBTRACT_CONSTANT_BORROW
        |=> done_ff && !busy_ff && !reject_ff) else $error("constant borrow timing wrong");
    a_sub_one_cycle:
    assert property (taken && opCode == `WSA_OP_SUBTRACT_REGISTERS
        |=> done_ff && !busy_ff && !reject_ff) else $error("register subtract timing wrong");
    a_done_has_cause:
    assert property (done_ff |-> $past(busy_ff) || ($past(taken) && $past(opCode) >= 3'h2
        && $past(opCode) <= 3'h5)) else $error("done without an operation");
    a_reject_unknown:
    assert property (taken && (opCode == 3'h0 || opCode > 3'h5) |=> reject_ff && !done_ff)
        else $error("unknown code not rejected");

    c_word: cover property (busy_ff ##1 done_ff);
    c_back_to_back: cover property (done_ff ##1 done_ff);
    c_reject: cover property (reject_ff);
endmodule // wsa_alu_checker

bind wsa_alu wsa_alu_checker #(.NUM_REGS(NUM_REGS)) u_wsa_alu_checker (
    .clk(clk), .rst(rst), .opValid(opValid), .opCode(opCode), .dstSel(dstSel),
    .srcSel(srcSel), .immVal(immVal), .busy_ff(busy_ff), .done_ff(done_ff),
    .reject_ff(reject_ff), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regRdData_ff(regRdData_ff));

// ---- wsa_alu_tb.sv ----
// self-checking bench for the word add and byte subtract datapath slice
// assumes wsa_alu with its checker bound, 200 MHz clock, no far-side model
`timescale 1ns/10ps
`include "wsa_defs.vh"

`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin errCount++; \
    $display("unexpected %s expected %h seen %h", nm, exp, got); end end

module wsa_alu_tb;
    typedef struct packed {
        logic [2:0]  op;
        logic [4:0]  dst;
        logic [15:0] a;
        logic [7:0]  k;
        logic        cin;
        logic [15:0] res;
        logic [7:0]  stat;
    } wsa_row_t;

    logic       clk = 0, rst = 1, opValid = 0, regWrEn = 0, regRdEn = 0;
    logic [2:0] opCode = 0;
    logic [4:0] dstSel = 0, srcSel = 0;
    logic [7:0] immVal = 0, regWrData = 0, got;
    logic [5:0] regAddr = 0, lo;
    wire        busy_ff, done_ff, reject_ff;
    wire  [7:0] regRdData_ff;
    wsa_row_t   rows [8];
    logic [2:0] badOps [3] = '{3'h0, 3'h6, 3'h7};
    wsa_row_t   r;
    int         errCount = 0, checks = 0;

    wsa_alu u_wsa_alu (.clk(clk), .rst(rst), .opValid(opValid), .opCode(opCode),
        .dstSel(dstSel), .srcSel(srcSel), .immVal(immVal), .busy_ff(busy_ff),
        .done_ff(done_ff), .reject_ff(reject_ff), .regAddr(regAddr), .regWrData(regWrData),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData_ff(regRdData_ff));

    always #2.5 clk = ~clk;

    task summarize;
        begin
            if (errCount == 0 && checks > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask

    task wr(input logic [5:0] a, input logic [7:0] d);
        begin
            @(posedge clk); regAddr <= a; regWrData <= d; regWrEn <= 1'b1;
            @(posedge clk); regWrEn <= 1'b0;
        end
    endtask

    // read data stands only in the cycle after the strobe
    task rd(input logic [5:0] a, output logic [7:0] d);
        begin
            @(posedge clk); regAddr <= a; regRdEn <= 1'b1;
            @(posedge clk); regRdEn <= 1'b0;
            #1 d = regRdData_ff;
        end
    endtask

    task doOp(input logic [2:0] c, input logic [4:0] d, input logic [7:0] k);
        int n;
        begin
            @(posedge clk); opValid <= 1'b1; opCode <= c; dstSel <= d; srcSel <= 5'd3;
            immVal <= k;
            @(posedge clk); opValid <= 1'b0;
            #1 n = 0;
            while (done_ff !== 1'b1 && reject_ff !== 1'b1) begin
                @(posedge clk); #1 n++;
                if (n > 4) begin errCount++; summarize(); end
            end
        end
    endtask

    initial begin
        // op, dst, start value, operand, carry in, result, status (S and bits 7,6 preset)
        rows[0] = '{3'h2, 5'd17, 16'h0010, 8'h01, 1'b1, 16'h000f, 8'hf0};
        rows[1] = '{3'h3, 5'd17, 16'h0080, 8'h01, 1'b0, 16'h007f, 8'hf8};
        rows[2] = '{3'h4, 5'd17, 16'h0005, 8'h05, 1'b1, 16'h00ff, 8'hf5};
        rows[3] = '{3'h5, 5'd17, 16'h0005, 8'h04, 1'b1, 16'h0000, 8'hd2};
        rows[4] = '{3'h3, 5'd17, 16'h0030, 8'h40, 1'b1, 16'h00f0, 8'hd5};
        rows[5] = '{3'h1, 5'd1,  16'h00ff, 8'h01, 1'b1, 16'h0100, 8'hc0};
        rows[6] = '{3'h1, 5'd0,  16'hffff, 8'hff, 1'b0, 16'h003e, 8'hc1};
        rows[7] = '{3'h1, 5'd3,  16'h7fff, 8'h01, 1'b0, 16'h8000, 8'hcc};
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        // ------------------------------------------------------------------
        // reset values, read-only and unmapped places
        // ------------------------------------------------------------------
        rd(`WSA_ADDR_STATUS, got); `CHK("status after reset", 8'h00, got)
        rd(6'h05, got);            `CHK("register after reset", 8'h00, got)
        wr(`WSA_ADDR_ENGINE, 8'hff);
        rd(`WSA_ADDR_ENGINE, got); `CHK("engine read only", 8'h00, got)
        wr(6'h20, 8'h5a);
        rd(6'h20, got);            `CHK("unmapped read", 8'h00, got)
        // ------------------------------------------------------------------
        // table of ordinary cases
        // ------------------------------------------------------------------
        foreach (rows[i]) begin
            r = rows[i];
            lo = (r.op == 3'h1) ? {1'b0, 2'b11, r.dst[1:0], 1'b0} : {2'b01, r.dst[3:0]};
            wr(`WSA_ADDR_STATUS, 8'hd0 | {7'h00, r.cin});
            wr(lo, r.a[7:0]);
            wr(lo + 6'd1, r.a[15:8]);
            wr(6'd3, r.k);
            doOp(r.op, r.dst, r.k);
            `CHK("done pulse", 1'b1, done_ff)
            rd(lo, got);      `CHK("result low", r.res[7:0], got)
            if (r.op == 3'h1) begin
                rd(lo + 6'd1, got); `CHK("result high", r.res[15:8], got)
            end
            rd(`WSA_ADDR_STATUS, got); `CHK("status", r.stat, got)
        end
        // ------------------------------------------------------------------
        // unknown codes leave state alone
        // ------------------------------------------------------------------
        wr(`WSA_ADDR_STATUS, 8'h00);
        foreach (badOps[j]) begin
            doOp(badOps[j], 5'd17, 8'h01);
            `CHK("reject pulse", 1'b1, reject_ff)
        end
        rd(`WSA_ADDR_STATUS, got); `CHK("status after reject", 8'h00, got)
        rd(6'd17, got);            `CHK("register after reject", 8'hf0, got)
        // ------------------------------------------------------------------
        // back-to-back byte ops, then a request while busy
        // ------------------------------------------------------------------
        wr(6'd16, 8'h10);
        @(posedge clk); opValid <= 1'b1; opCode <= `WSA_OP_SUBTRACT_CONSTANT;
        dstSel <= 5'd0; immVal <= 8'h01;
        @(posedge clk); immVal <= 8'h02;
        @(posedge clk); opValid <= 1'b0;
        rd(6'd16, got); `CHK("back to back", 8'h0d, got)
        wr(6'd24, 8'h00);
        wr(6'd25, 8'h00);
        @(posedge clk); opValid <= 1'b1; opCode <= `WSA_OP_ADD_IMMEDIATE_WORD;
        dstSel <= 5'd0; immVal <= 8'h05;
        @(posedge clk); opCode <= `WSA_OP_SUBTRACT_CONSTANT;
        #1 `CHK("busy in word op", 1'b1, busy_ff)
        @(posedge clk); opValid <= 1'b0;
        rd(6'd24, got); `CHK("word while busy", 8'h05, got)
        rd(6'd16, got); `CHK("ignored request", 8'h0d, got)
        // ------------------------------------------------------------------
        // reset in mid-run clears the register file and flags
        // ------------------------------------------------------------------
        @(posedge clk); rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(6'd16, got);            `CHK("register after second reset", 8'h00, got)
        rd(`WSA_ADDR_STATUS, got); `CHK("status after second reset", 8'h00, got)
        summarize();
    end
endmodule // wsa_alu_tb

// ---- wsa_defs.vh ----
// constants shared by the word add and byte subtract datapath slice
// assumes inclusion by bare name from every design file of the slice
`ifndef WSA_DEFS_VH
`define WSA_DEFS_VH

// ----------------------------------------------------------------------
// operation codes on the request port
// ----------------------------------------------------------------------
`define WSA_OP_W                         3
`define WSA_OP_ADD_IMMEDIATE_WORD        3'h1
`define WSA_OP_SUBTRACT_REGISTERS        3'h2
`define WSA_OP_SUBTRACT_CONSTANT         3'h3
`define WSA_OP_SUBTRACT_REGISTERS_BORROW 3'h4
`define WSA_OP_SUBTRACT_CONSTANT_BORROW  3'h5

// ----------------------------------------------------------------------
// status flag bit positions
// ----------------------------------------------------------------------
`define WSA_FLAG_C 0
`define WSA_FLAG_Z 1
`define WSA_FLAG_N 2
`define WSA_FLAG_V 3
`define WSA_FLAG_S 4
`define WSA_FLAG_H 5

// ----------------------------------------------------------------------
// register port map and reset values
// ----------------------------------------------------------------------
`define WSA_ADDR_W         6
`define WSA_ADDR_GPR_LAST  6'h1f
`define WSA_ADDR_ENGINE    6'h3e
`define WSA_ADDR_STATUS    6'h3f
`define WSA_STATUS_RST     8'h00
`define WSA_GPR_RST        8'h00
`define WSA_ENGINE_BUSY    0

// ----------------------------------------------------------------------
// register selection and timing
// ----------------------------------------------------------------------
`define WSA_PAIR_PREFIX    2'h3
`define WSA_UPPER_BANK     1'h1
`define WSA_WORD_IMM_W     6
`define WSA_WORD_CYCLES    2
`define WSA_BYTE_CYCLES    1

`endif

// ---- wsa_sub8.v ----
// byte subtractor with borrow in, producing difference and the five flags
// assumes purely combinational use inside the datapath, same clock domain
`timescale 1ns/10ps

module wsa_sub8 (
    input  wire [7:0] minuend,
    input  wire [7:0] subtrahend,
    input  wire       borrowIn,
    output wire [7:0] diff,
    output wire       borrowOut,
    output wire       zero,
    output wire       neg,
    output wire       ovf,
    output wire       halfBorrow
);

    // ------------------------------------------------------------------
    // full and nibble differences, top bit is the borrow
    // ------------------------------------------------------------------
    wire [8:0] fullDiff;
    wire [4:0] nibDiff;

    assign fullDiff   = {1'b0, minuend} - {1'b0, subtrahend} - {8'h00, borrowIn};
    assign nibDiff    = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]} - {4'h0, borrowIn};
    assign diff       = fullDiff[7:0];
    assign borrowOut  = fullDiff[8];
    assign halfBorrow = nibDiff[4];
    assign zero       = (fullDiff[7:0] == 8'h00);
    assign neg        = fullDiff[7];
    // signs differ and result sign follows the subtrahend
    assign ovf        = (minuend[7] & ~subtrahend[7] & ~fullDiff[7]) |
                        (~minuend[7] & subtrahend[7] & fullDiff[7]);

endmodule // wsa_sub8
